// ### hdl/ppo_top.sv
// One GPIO port: AXI4-Lite registers, override merge, input sync, pin interrupts
//
// Summary of operation
// (RQ1) Deep sleep clamps each pin's digital input low unless an override enables it.
// (RQ2) A pin with its external interrupt enabled is exempt from the sleep clamp.
// (RQ3) Edge-sensed disabled interrupt pin held high gets its flag on wake.
// (RQ4) Pull-ups stay off throughout reset.
// (RQ5) Pull-up follows its override value if enabled, else only when dir/out/gpd=0b010.
// (RQ6) Direction override enable selects override value, else direction bit drives.
// (RQ7) Driven value is override value if enabled, else the output register bit.
// (RQ8) Toggle override inverts the output register bit while asserted.
// (RQ9) Input-enable override selects its value, else normal or sleep state decides.
// (RQ10) Alternate digital input is tapped after the input gate, before the synchroniser.
// (RQ11) Peripherals must synchronise the alternate digital input unless used as clock.
// (RQ12) Analog alternate path connects straight to the pad, both directions; here pad to alt_analog_io_o only.
// (RQ13) Peripherals generate each pin's override enables and values themselves.
// (RQ14) Strobes shared per port; clock, sleep, global disable shared; overrides per pin.
// (RQ15) Direction bit one makes the pin an output, zero an input.
// (RQ16) Input pin with output bit one and global disable clear gets its pull-up.
// (RQ17) Writing one to an input register bit toggles the matching output bit.
// (RQ18) Pin level passes a sync stage, then lands in the input register.
// (RQ19) With the driver disabled the pad is undriven apart from the pull-up.
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
module ppo_top
   import ppo_pkg::*;
#(
   parameter int NUM_PINS = 8
)(
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   // AXI4-Lite slave
   input wire logic [PPO_ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [PPO_ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // Sleep controller gate, shared by all ports
   input wire logic sleep_i,
   // Per-pin overrides from peripherals owning alternate functions
   input wire logic [NUM_PINS-1:0] pullup_ovr_en_i,
   input wire logic [NUM_PINS-1:0] pullup_ovr_val_i,
   input wire logic [NUM_PINS-1:0] dir_ovr_en_i,
   input wire logic [NUM_PINS-1:0] dir_ovr_val_i,
   input wire logic [NUM_PINS-1:0] outval_ovr_en_i,
   input wire logic [NUM_PINS-1:0] outval_ovr_val_i,
   input wire logic [NUM_PINS-1:0] toggle_ovr_en_i,
   input wire logic [NUM_PINS-1:0] inen_ovr_en_i,
   input wire logic [NUM_PINS-1:0] inen_ovr_val_i,
   output logic [NUM_PINS-1:0] alt_digital_in_o,
   output logic [NUM_PINS-1:0] alt_analog_io_o,
   // Pad
   input wire logic [NUM_PINS-1:0] pad_i,
   output logic [NUM_PINS-1:0] pad_o,
   output logic [NUM_PINS-1:0] pad_oe_o,
   output logic [NUM_PINS-1:0] pad_pullup_en_o,
   output logic irq_o
);
   if (NUM_PINS < 1 || NUM_PINS > 8) begin : g_chk
      $error("NUM_PINS must be 1 to 8");
   end

   localparam int SW = NUM_PINS * PPO_SENSE_W;

   // Byte-lane merge of a write into an old register value
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
         input logic [31:0] new_v, input logic [3:0] strb);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return (old_v & ~m) | (new_v & m);
   endfunction

   function automatic logic addr_known(input logic [PPO_ADDR_W-1:0] a);
      return (a == PPO_DIR_OFS) || (a == PPO_OUT_OFS) || (a == PPO_IN_OFS) ||
         (a == PPO_CTRL_OFS) || (a == PPO_EXTEN_OFS) || (a == PPO_SENSE_OFS) ||
         (a == PPO_STAT_OFS) || (a == PPO_MASK_OFS);
   endfunction

   logic [NUM_PINS-1:0] dir_r;
   logic [NUM_PINS-1:0] out_r;
   logic [NUM_PINS-1:0] out_nxt;
   logic gpd_r;
   logic [NUM_PINS-1:0] ext_en_r;
   logic [SW-1:0] sense_r;
   logic [NUM_PINS-1:0] stat_r;
   logic [NUM_PINS-1:0] stat_nxt;
   logic [NUM_PINS-1:0] mask_r;
   logic [NUM_PINS-1:0] sync_r;
   logic [NUM_PINS-1:0] pin_in_r;
   logic [NUM_PINS-1:0] pin_prev_r;
   // Fills with ones as the sync, input and previous-level stages become valid
   logic [2:0] warm_r;

   // AXI state
   logic aw_hold_r;
   logic w_hold_r;
   logic [PPO_ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;

   // Items are taken only while ready is shown, so the master always sees the take
   wire aw_hs = s_axi_awvalid_i & s_axi_awready_o;
   wire w_hs = s_axi_wvalid_i & s_axi_wready_o;
   wire ar_hs = s_axi_arvalid_i & s_axi_arready_o;
   wire do_wr = aw_hold_r & w_hold_r & ~bvalid_r;
   wire [31:0] wr_dir = lane_merge(32'(dir_r), wdata_r, wstrb_r);
   wire [31:0] wr_out = lane_merge(32'(out_r), wdata_r, wstrb_r);
   wire [31:0] wr_ctrl = lane_merge(32'(gpd_r), wdata_r, wstrb_r);
   wire [31:0] wr_exten = lane_merge(32'(ext_en_r), wdata_r, wstrb_r);
   wire [31:0] wr_sense = lane_merge(32'(sense_r), wdata_r, wstrb_r);
   wire [31:0] wr_mask = lane_merge(32'(mask_r), wdata_r, wstrb_r);
   wire [31:0] wr_ones = wdata_r & {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
      {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
   // Write strobes are per register, shared by every pin of the port
   wire wr_dir_stb = do_wr & (awaddr_r == PPO_DIR_OFS); // RQ14
   wire wr_out_stb = do_wr & (awaddr_r == PPO_OUT_OFS); // RQ14
   wire wr_in_stb = do_wr & (awaddr_r == PPO_IN_OFS); // RQ14
   wire wr_ctrl_stb = do_wr & (awaddr_r == PPO_CTRL_OFS);
   wire wr_exten_stb = do_wr & (awaddr_r == PPO_EXTEN_OFS);
   wire wr_sense_stb = do_wr & (awaddr_r == PPO_SENSE_OFS);
   wire wr_stat_stb = do_wr & (awaddr_r == PPO_STAT_OFS);
   wire wr_mask_stb = do_wr & (awaddr_r == PPO_MASK_OFS);

   // Read data select
   logic [31:0] rd_mux;
   always_comb begin
      case (s_axi_araddr_i)
         PPO_DIR_OFS: rd_mux = 32'(dir_r);
         PPO_OUT_OFS: rd_mux = 32'(out_r);
         PPO_IN_OFS: rd_mux = 32'(pin_in_r);
         PPO_CTRL_OFS: rd_mux = 32'(gpd_r);
         PPO_EXTEN_OFS: rd_mux = 32'(ext_en_r);
         PPO_SENSE_OFS: rd_mux = 32'(sense_r);
         PPO_STAT_OFS: rd_mux = 32'(stat_r);
         PPO_MASK_OFS: rd_mux = 32'(mask_r);
         default: rd_mux = PPO_REG_RST;
      endcase
   end

   // Output bit: plain write, or toggle by writing ones to the input register
   always_comb begin
      out_nxt = out_r;
      if (wr_out_stb) begin
         out_nxt = wr_out[NUM_PINS-1:0];
      end else if (wr_in_stb) begin
         out_nxt = out_r ^ wr_ones[NUM_PINS-1:0]; // RQ17
      end
   end

   // Pin interrupt detection on the synchronised, sleep-gated level
   logic [NUM_PINS-1:0] evt;
   logic [NUM_PINS-1:0] drv_en_w;
   logic [NUM_PINS-1:0] drv_val_w;
   logic [NUM_PINS-1:0] pu_en_w;
   logic [NUM_PINS-1:0] din_w;

   for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      wire [1:0] sense = sense_r[i*PPO_SENSE_W +: PPO_SENSE_W];
      wire rise = pin_in_r[i] & ~pin_prev_r[i];
      wire fall = ~pin_in_r[i] & pin_prev_r[i];
      // The clamp pulls a high pin low in sleep, so waking releases an edge
      // that the detector sees even while the interrupt itself is disabled
      // Held off until the stages are filled, else the reset zeros look like events
      assign evt[i] = warm_r[2] & ((sense == PPO_SENSE_LOW) ? ~pin_in_r[i] :
         (sense == PPO_SENSE_ANY) ? (rise | fall) :
         (sense == PPO_SENSE_FALL) ? fall : rise); // RQ3
      ppo_pin_if pif ();
      assign pif.dir_bit = dir_r[i];
      assign pif.out_bit = out_r[i];
      assign pif.gpd = gpd_r; // RQ14
      assign pif.sleep = sleep_i; // RQ14
      assign pif.ext_en = ext_en_r[i]; // RQ2
      assign pif.pu_oe = pullup_ovr_en_i[i];
      assign pif.pu_ov = pullup_ovr_val_i[i];
      assign pif.dd_oe = dir_ovr_en_i[i];
      assign pif.dd_ov = dir_ovr_val_i[i];
      assign pif.pv_oe = outval_ovr_en_i[i];
      assign pif.pv_ov = outval_ovr_val_i[i];
      assign pif.pt_oe = toggle_ovr_en_i[i];
      assign pif.die_oe = inen_ovr_en_i[i];
      assign pif.die_ov = inen_ovr_val_i[i];
      assign pif.pad_in = pad_i[i];
      assign drv_en_w[i] = pif.drv_en;
      assign drv_val_w[i] = pif.drv_val;
      assign pu_en_w[i] = pif.pu_en;
      assign din_w[i] = pif.din_gated;
      ppo_pin_ctl u_pin (
         .pin(pif)
      );
   end

   // Hardware set wins over a software clear in the same cycle
   assign stat_nxt = (stat_r & ~(wr_stat_stb ? wr_ones[NUM_PINS-1:0] :
      {NUM_PINS{1'b0}})) | evt;

   // Unsynchronised tap for peripherals; they add their own synchroniser
   assign alt_digital_in_o = din_w; // RQ10 RQ11
   // Analog path bypasses every gate; it carries the pad level to the peripheral only
   assign alt_analog_io_o = pad_i; // RQ12

   // Register file
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dir_r <= '0;
         out_r <= '0;
         gpd_r <= 1'b0;
         ext_en_r <= '0;
         sense_r <= '0;
         stat_r <= '0;
         mask_r <= '0;
      end else begin
         if (wr_dir_stb) dir_r <= wr_dir[NUM_PINS-1:0];
         out_r <= out_nxt;
         if (wr_ctrl_stb) gpd_r <= wr_ctrl[PPO_CTRL_GPD_BIT];
         if (wr_exten_stb) ext_en_r <= wr_exten[NUM_PINS-1:0];
         if (wr_sense_stb) sense_r <= wr_sense[SW-1:0];
         stat_r <= stat_nxt;
         if (wr_mask_stb) mask_r <= wr_mask[NUM_PINS-1:0];
      end
   end

   // Input sync: the first stage stands in for the half-cycle latch
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sync_r <= '0;
         pin_in_r <= '0;
         pin_prev_r <= '0;
         warm_r <= '0;
      end else begin
         warm_r <= {warm_r[1:0], 1'b1};
         sync_r <= din_w; // RQ18
         pin_in_r <= sync_r; // RQ18
         pin_prev_r <= pin_in_r;
      end
   end

   // Pad drive, pull-up and interrupt, all from flops
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pad_oe_o <= '0;
         pad_o <= '0;
         pad_pullup_en_o <= '0; // RQ4
         irq_o <= 1'b0;
      end else begin
         pad_oe_o <= drv_en_w; // RQ6 RQ19
         pad_o <= drv_val_w; // RQ7 RQ19
         pad_pullup_en_o <= pu_en_w; // RQ5 RQ16
         irq_o <= |(stat_nxt & mask_r);
      end
   end

   // AXI4-Lite write channel: address and data taken in either order
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
         bvalid_r <= 1'b0;
         bresp_r <= PPO_RESP_OKAY;
      end else begin
         if (aw_hs) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr_i;
         end
         if (w_hs) begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata_i;
            wstrb_r <= s_axi_wstrb_i;
         end
         if (do_wr) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= addr_known(awaddr_r) ? PPO_RESP_OKAY : PPO_RESP_SLVERR;
         end else if (bvalid_r && s_axi_bready_i) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // AXI4-Lite read channel
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rvalid_r <= 1'b0;
         rdata_r <= PPO_REG_RST;
         rresp_r <= PPO_RESP_OKAY;
      end else if (ar_hs) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_mux;
         rresp_r <= addr_known(s_axi_araddr_i) ? PPO_RESP_OKAY : PPO_RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready_i) begin
         rvalid_r <= 1'b0;
      end
   end

   // Ready outputs are registered copies of the next-cycle acceptance state
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o <= 1'b0;
         s_axi_arready_o <= 1'b0;
      end else begin
         s_axi_awready_o <= ~(aw_hold_r | aw_hs) & ~(bvalid_r | do_wr);
         s_axi_wready_o <= ~(w_hold_r | w_hs) & ~(bvalid_r | do_wr);
         s_axi_arready_o <= ~(rvalid_r | ar_hs);
      end
   end

   assign s_axi_bvalid_o = bvalid_r;
   assign s_axi_bresp_o = bresp_r;
   assign s_axi_rvalid_o = rvalid_r;
   assign s_axi_rdata_o = rdata_r;
   assign s_axi_rresp_o = rresp_r;
endmodule

// ### hdl/ppo_pkg.sv
// Constants shared by the port pin override logic
package ppo_pkg;
   // Register byte offsets on the AXI4-Lite bus
   localparam logic [7:0] PPO_DIR_OFS = 8'h00;
   localparam logic [7:0] PPO_OUT_OFS = 8'h04;
   localparam logic [7:0] PPO_IN_OFS = 8'h08;
   localparam logic [7:0] PPO_CTRL_OFS = 8'h0C;
   localparam logic [7:0] PPO_EXTEN_OFS = 8'h10;
   localparam logic [7:0] PPO_SENSE_OFS = 8'h14;
   localparam logic [7:0] PPO_STAT_OFS = 8'h18;
   localparam logic [7:0] PPO_MASK_OFS = 8'h1C;
   localparam int PPO_ADDR_W = 8;
   // Field positions
   localparam int PPO_CTRL_GPD_BIT = 0;
   localparam int PPO_SENSE_W = 2;
   // Reset values
   localparam logic [31:0] PPO_REG_RST = 32'h0000_0000;
   // External interrupt sense codes, two bits per pin
   localparam logic [1:0] PPO_SENSE_LOW = 2'h0;
   localparam logic [1:0] PPO_SENSE_ANY = 2'h1;
   localparam logic [1:0] PPO_SENSE_FALL = 2'h2;
   localparam logic [1:0] PPO_SENSE_RISE = 2'h3;
   // AXI response codes
   localparam logic [1:0] PPO_RESP_OKAY = 2'h0;
   localparam logic [1:0] PPO_RESP_SLVERR = 2'h2;
endpackage

// ### hdl/ppo_pin_if.sv
// Per-pin control bundle between the port and one pin resolver
`timescale 1ns/100ps
interface ppo_pin_if;
   logic dir_bit;
   logic out_bit;
   logic gpd;
   logic sleep;
   logic ext_en;
   logic pu_oe;
   logic pu_ov;
   logic dd_oe;
   logic dd_ov;
   logic pv_oe;
   logic pv_ov;
   logic pt_oe;
   logic die_oe;
   logic die_ov;
   logic pad_in;
   logic drv_en;
   logic drv_val;
   logic pu_en;
   logic din_gated;
   modport ctl (
      input dir_bit, out_bit, gpd, sleep, ext_en, pu_oe, pu_ov, dd_oe, dd_ov,
      input pv_oe, pv_ov, pt_oe, die_oe, die_ov, pad_in,
      output drv_en, drv_val, pu_en, din_gated
   );
   modport port (
      output dir_bit, out_bit, gpd, sleep, ext_en, pu_oe, pu_ov, dd_oe, dd_ov,
      output pv_oe, pv_ov, pt_oe, die_oe, die_ov, pad_in,
      input drv_en, drv_val, pu_en, din_gated
   );
endinterface

// ### hdl/ppo_pin_ctl.sv
// Override resolution for one pin: driver, value, pull-up and input gate
`timescale 1ns/100ps
module ppo_pin_ctl
   import ppo_pkg::*;
(
   ppo_pin_if.ctl pin
);
   wire port_val;
   wire in_en;
   wire pu_normal;

   assign port_val = pin.out_bit ^ pin.pt_oe; // RQ8
   assign pin.drv_en = pin.dd_oe ? pin.dd_ov : pin.dir_bit; // RQ6 RQ15
   // Value is forced low when not driving so the pad only sees the enable
   assign pin.drv_val = pin.drv_en & (pin.pv_oe ? pin.pv_ov : port_val); // RQ7 RQ19
   assign pu_normal = ~pin.dir_bit & pin.out_bit & ~pin.gpd; // RQ16
   assign pin.pu_en = pin.pu_oe ? pin.pu_ov : pu_normal; // RQ5
   // Deep sleep clamps the input unless an armed external interrupt holds it open
   assign in_en = pin.die_oe ? pin.die_ov : (~pin.sleep | pin.ext_en); // RQ1 RQ2 RQ9
   assign pin.din_gated = pin.pad_in & in_en; // RQ1 RQ10
endmodule

// ### verification/ppo_periph_model.sv
// Peripheral owning alternate functions: drives overrides, samples the raw input
`timescale 1ns/100ps
module ppo_periph_model (
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic en_i,
   input wire logic [71:0] req_i,
   input wire logic [7:0] alt_digital_in_i,
   output logic [71:0] ovr_o,
   output logic [7:0] din_sync_o
);
   logic [7:0] din_meta_r;
   // Field order: pu en/val, dir en/val, value en/val, toggle en, input en/val
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ovr_o <= '0;
         din_meta_r <= '0;
         din_sync_o <= '0;
      end else begin
         ovr_o <= en_i ? req_i : 72'h0;
         // Raw input is unrelated to our clock, so two flops before use
         din_meta_r <= alt_digital_in_i;
         din_sync_o <= din_meta_r;
      end
   end
endmodule

// ### verification/ppo_top_assertions.sv
// Port-level assertions for the pin override logic
`timescale 1ns/100ps
module ppo_top_assertions #(
   parameter int NUM_PINS = 8
)(
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic sleep_i,
   input wire logic [NUM_PINS-1:0] pullup_ovr_en_i,
   input wire logic [NUM_PINS-1:0] pullup_ovr_val_i,
   input wire logic [NUM_PINS-1:0] dir_ovr_en_i,
   input wire logic [NUM_PINS-1:0] dir_ovr_val_i,
   input wire logic [NUM_PINS-1:0] inen_ovr_en_i,
   input wire logic [NUM_PINS-1:0] inen_ovr_val_i,
   input wire logic [NUM_PINS-1:0] alt_digital_in_o,
   input wire logic [NUM_PINS-1:0] alt_analog_io_o,
   input wire logic [NUM_PINS-1:0] pad_i,
   input wire logic [NUM_PINS-1:0] pad_o,
   input wire logic [NUM_PINS-1:0] pad_oe_o,
   input wire logic [NUM_PINS-1:0] pad_pullup_en_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!arst_n_i);
   // Watched during reset, so it opts out of the default disable
   property p_pu_rst;
      disable iff (1'b0) !arst_n_i |-> pad_pullup_en_o == '0;
   endproperty
   a_pu_rst: assert property (p_pu_rst) else $error("pull-up on in reset");
   property p_pu_ovr;
      pullup_ovr_en_i != '0 |=>
         ((pad_pullup_en_o ^ $past(pullup_ovr_val_i)) & $past(pullup_ovr_en_i)) == '0;
   endproperty
   a_pu_ovr: assert property (p_pu_ovr) else $error("pull-up override ignored");
   property p_dir_ovr;
      dir_ovr_en_i != '0 |=> ((pad_oe_o ^ $past(dir_ovr_val_i)) & $past(dir_ovr_en_i)) == '0;
   endproperty
   a_dir_ovr: assert property (p_dir_ovr) else $error("direction override ignored");
   property p_undriven;
      (pad_o & ~pad_oe_o) == '0;
   endproperty
   a_undriven: assert property (p_undriven) else $error("value on undriven pad");
   property p_in_off;
      inen_ovr_en_i != '0 |-> (alt_digital_in_o & inen_ovr_en_i & ~inen_ovr_val_i) == '0;
   endproperty
   a_in_off: assert property (p_in_off) else $error("input not gated off");
   property p_in_on;
      inen_ovr_en_i != '0 |-> ((alt_digital_in_o ^ pad_i) & inen_ovr_en_i & inen_ovr_val_i) == '0;
   endproperty
   a_in_on: assert property (p_in_on) else $error("input not forced on");
   property p_awake;
      !sleep_i |-> ((alt_digital_in_o ^ pad_i) & ~inen_ovr_en_i) == '0;
   endproperty
   a_awake: assert property (p_awake) else $error("input wrong when awake");
   property p_analog;
      alt_analog_io_o == pad_i;
   endproperty
   a_analog: assert property (p_analog) else $error("analog path not the pad");
endmodule
bind ppo_top ppo_top_assertions #(.NUM_PINS(NUM_PINS)) u_chk (
   .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .sleep_i(sleep_i),
   .pullup_ovr_en_i(pullup_ovr_en_i), .pullup_ovr_val_i(pullup_ovr_val_i),
   .dir_ovr_en_i(dir_ovr_en_i), .dir_ovr_val_i(dir_ovr_val_i),
   .inen_ovr_en_i(inen_ovr_en_i), .inen_ovr_val_i(inen_ovr_val_i),
   .alt_digital_in_o(alt_digital_in_o), .alt_analog_io_o(alt_analog_io_o), .pad_i(pad_i),
   .pad_o(pad_o), .pad_oe_o(pad_oe_o), .pad_pullup_en_o(pad_pullup_en_o)
);

// ### verification/tb_port_pin_override_logic.sv
// Self-checking bench for the port pin override logic
`timescale 1ns/100ps
module tb_port_pin_override_logic;
   import ppo_pkg::*;
   logic clk = 1'b0, rst_n = 1'b1, sleep = 1'b0, pen = 1'b0, g = 1'b0;
   logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic [7:0] awa = '0, ara = '0, ext = 8'hFF, d = '0, o = '0, x = '0, lv;
   logic [31:0] wd = '0;
   logic [71:0] req = '0, t = '0;
   logic [15:0] rnd = 16'h0013;
   logic [33:0] q[$];
   wire awr, wry, bv, arr, rv, irq;
   wire [1:0] brs, rrs;
   wire [31:0] rdt;
   wire [71:0] ovr;
   wire [7:0] ad, aa, pad, po, poe, pu, ds;
   int n_mismatch = 0, n_compared = 0, cyc = 0;
   // Released pads read high with the pull-up on, else float to whatever the board holds them at
   assign pad = (poe & po) | (~poe & pu) | (~poe & ~pu & ext);
   always #20 clk = ~clk;
   ppo_top #(.NUM_PINS(8)) dut (
      .core_clk_i(clk), .arst_n_i(rst_n), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
      .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
      .s_axi_wready_o(wry), .s_axi_bresp_o(brs), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
      .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
      .s_axi_rdata_o(rdt), .s_axi_rresp_o(rrs), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
      .sleep_i(sleep), .pullup_ovr_en_i(ovr[71:64]), .pullup_ovr_val_i(ovr[63:56]),
      .dir_ovr_en_i(ovr[55:48]), .dir_ovr_val_i(ovr[47:40]), .outval_ovr_en_i(ovr[39:32]),
      .outval_ovr_val_i(ovr[31:24]), .toggle_ovr_en_i(ovr[23:16]), .inen_ovr_en_i(ovr[15:8]),
      .inen_ovr_val_i(ovr[7:0]), .alt_digital_in_o(ad), .alt_analog_io_o(aa), .pad_i(pad),
      .pad_o(po), .pad_oe_o(poe), .pad_pullup_en_o(pu), .irq_o(irq)
   );
   ppo_periph_model peri (
      .core_clk_i(clk), .arst_n_i(rst_n), .en_i(pen), .req_i(req), .alt_digital_in_i(ad),
      .ovr_o(ovr), .din_sync_o(ds)
   );
   function automatic logic [15:0] lf(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task chk(input logic [33:0] got, input logic [33:0] ex);
      n_compared++;
      if (got !== ex) begin
         n_mismatch++;
         $display("Error %0t: got %h expected %h", $time, got, ex);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] dt, input logic [1:0] er);
      awa <= a;
      wd <= dt;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do begin
         @(posedge clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wry) wv <= 1'b0;
      end while (!bv);
      // bready stays high between writes, so back-to-back calls never clash
      chk({32'h0, brs}, {32'h0, er});
   endtask
   task rd(input logic [7:0] a, input logic [33:0] ex);
      q.push_back(ex);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do begin
         @(posedge clk);
         if (arv && arr) arv <= 1'b0;
      end while (!rv);
   endtask
   // Expected pad state from registers, overrides and sleep
   task pins;
      logic [71:0] r;
      logic [7:0] oe, v, pe, ie;
      repeat (6) @(posedge clk);
      r = pen ? req : 72'h0;
      oe = (r[55:48] & r[47:40]) | (~r[55:48] & d);
      v = oe & ((r[39:32] & r[31:24]) | (~r[39:32] & (o ^ r[23:16])));
      pe = (r[71:64] & r[63:56]) | (~r[71:64] & ~d & o & ~{8{g}});
      ie = (r[15:8] & r[7:0]) | (~r[15:8] & ({8{~sleep}} | x));
      lv = (oe & v) | (~oe & pe) | (~oe & ~pe & ext);
      chk(poe, oe);
      chk(po, v);
      chk(pu, pe);
      chk(ad, lv & ie);
      chk(ds, lv & ie);
      chk(aa, lv);
   endtask
   always @(posedge clk) begin
      if (rv && rry) chk({rrs, rdt}, q.pop_front());
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   task end_of_test;
      $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      rst_n <= 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      for (int i = 0; i < 8; i++) rd(8'(i * 4), {2'h0, (i == 2) ? 32'hFF : PPO_REG_RST});
      rd(8'h20, {PPO_RESP_SLVERR, 32'h0});
      wr(8'h24, 32'h1, PPO_RESP_SLVERR);
      $display("reset and decode test done");
      for (int i = 0; i < 8; i++) begin
         rnd = lf(rnd);
         d = rnd[7:0];
         o = rnd[15:8];
         g = i[0];
         ext <= d ^ 8'h5A;
         wr(PPO_DIR_OFS, {24'h0, d}, PPO_RESP_OKAY);
         wr(PPO_OUT_OFS, {24'h0, o}, PPO_RESP_OKAY);
         wr(PPO_CTRL_OFS, {31'h0, g}, PPO_RESP_OKAY);
         pins();
         rd(PPO_IN_OFS, {PPO_RESP_OKAY, 24'h0, lv});
         rnd = lf(rnd);
         wr(PPO_IN_OFS, {24'h0, rnd[7:0]}, PPO_RESP_OKAY);
         o = o ^ rnd[7:0];
         rd(PPO_OUT_OFS, {PPO_RESP_OKAY, 24'h0, o});
      end
      $display("static pin test done");
      pen <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         repeat (5) begin
            rnd = lf(rnd);
            t = {t[55:0], rnd};
         end
         req <= t;
         ext <= rnd[7:0];
         sleep <= rnd[9];
         pins();
      end
      pen <= 1'b0;
      sleep <= 1'b0;
      ext <= 8'hFF;
      $display("override test done");
      wr(PPO_DIR_OFS, 32'h0, PPO_RESP_OKAY);
      d = '0;
      wr(PPO_MASK_OFS, 32'h1, PPO_RESP_OKAY);
      wr(PPO_SENSE_OFS, 32'h0000_FFFF, PPO_RESP_OKAY);
      wr(PPO_STAT_OFS, 32'hFF, PPO_RESP_OKAY);
      rd(PPO_STAT_OFS, {PPO_RESP_OKAY, 32'h0});
      // Rising, unarmed then armed; then any-change and falling, both unarmed
      for (int k = 0; k < 4; k++) begin
         x = {8{k == 1}};
         wr(PPO_EXTEN_OFS, {24'h0, x}, PPO_RESP_OKAY);
         if (k > 1) begin
            wr(PPO_SENSE_OFS, (k == 2) ? 32'h0000_5555 : 32'h0000_AAAA, PPO_RESP_OKAY);
         end
         sleep <= 1'b1;
         pins();
         sleep <= 1'b0;
         pins();
         rd(PPO_STAT_OFS, {PPO_RESP_OKAY, 24'h0, ~x});
         repeat (2) @(posedge clk);
         chk({33'h0, irq}, {33'h0, ~x[0]});
         wr(PPO_MASK_OFS, 32'h0, PPO_RESP_OKAY);
         repeat (2) @(posedge clk);
         chk({33'h0, irq}, 34'h0);
         wr(PPO_MASK_OFS, 32'h1, PPO_RESP_OKAY);
         wr(PPO_STAT_OFS, 32'hFF, PPO_RESP_OKAY);
         repeat (2) @(posedge clk);
         chk({33'h0, irq}, 34'h0);
         rd(PPO_STAT_OFS, {PPO_RESP_OKAY, 32'h0});
      end
      $display("interrupt and wake test done");
      end_of_test();
   end
endmodule
